// file: logic/pmic_pkg.sv
/*
  Shared constants and types of the power-state and reset controller:
  timing figures with derived cycle counts, pin-function codes, pin and
  resource positions, off-source positions and the power-state enum.
  Assumes a 100 MHz system clock.
*/
package pmic_pkg;
  // clock rate
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int US_PER_MS = 1000;

  // button debounce periods per select code
  localparam int DEB0_MS = 15;
  localparam int DEB1_MS = 100;
  localparam int DEB2_MS = 500;
  localparam int DEB3_MS = 1000;
  localparam int DEB0_CYC = DEB0_MS * US_PER_MS * CYC_PER_US;
  localparam int DEB1_CYC = DEB1_MS * US_PER_MS * CYC_PER_US;
  localparam int DEB2_CYC = DEB2_MS * US_PER_MS * CYC_PER_US;
  localparam int DEB3_CYC = DEB3_MS * US_PER_MS * CYC_PER_US;

  // switch-off delays per code; code 0 is no delay
  localparam int DLY1_MS = 1;
  localparam int DLY2_MS = 2;
  localparam int DLY3_MS = 4;
  localparam int DLY1_CYC = DLY1_MS * US_PER_MS * CYC_PER_US;
  localparam int DLY2_CYC = DLY2_MS * US_PER_MS * CYC_PER_US;
  localparam int DLY3_CYC = DLY3_MS * US_PER_MS * CYC_PER_US;

  // spacing between two sequenced resources
  localparam int SEQ_STEP_US = 550;
  localparam int SEQ_STEP_CYC = SEQ_STEP_US * CYC_PER_US;

  // pin-function codes
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_ALT = 2'h1;
  localparam logic [1:0] FUNC_HOLD = 2'h2;

  // pins carrying alternative functions
  localparam int PIN_REGEN_B = 2;
  localparam int PIN_SYSEN_A = 4;
  localparam int PIN_SYSEN_B = 6;
  localparam int PIN_HOLD = 7;
  localparam int NUM_PINS = 8;

  // resource positions in the enable vector (also sequence order)
  localparam int RES_SYSEN_A = 4;
  localparam int RES_SYSEN_B = 5;
  localparam int RES_REGEN_A = 6;
  localparam int RES_REGEN_B = 7;
  localparam int MIN_RES = 8;

  // off-source positions
  localparam int SRC_LONG_PRESS = 0;
  localparam int SRC_POWER_DOWN = 1;
  localparam int SRC_WATCHDOG = 2;
  localparam int SRC_THERMAL = 3;
  localparam int SRC_RESET_IN = 4;
  localparam int SRC_SW_RESET = 5;
  localparam int SRC_SUPPLY_LOW = 6;
  localparam int SRC_CONVERTER = 7;
  localparam int NUM_SRC = 8;

  // fixed encodings and reset values
  localparam logic CTRL_I2C = 1'b0;
  localparam logic DRIVE_PUSH_PULL = 1'b0;
  localparam logic [6:0] PAGE_ADDR_DEF = 7'h12;
  localparam logic HOLD_RST = 1'b0;
  localparam logic [1:0] DEB_SEL_RST = 2'h0;

  typedef enum logic [2:0] {
    ST_BACKUP,
    ST_OFF,
    ST_UP,
    ST_ACTIVE,
    ST_SLEEP,
    ST_DELAY,
    ST_DOWN
  } pwr_state_t;
endpackage : pmic_pkg

// file: logic/debounce_if.sv
/*
  Carrier between the controller and its button debouncer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface debounce_if #(parameter int CW = 28);
  logic rawPressed;
  logic [CW-1:0] stableCycles;
  logic pressed;
  logic pressPulse;
  modport ctrl (output rawPressed, output stableCycles, input pressed, input pressPulse);
  modport filt (input rawPressed, input stableCycles, output pressed, output pressPulse);
endinterface : debounce_if

// file: logic/button_debounce.sv
/*
  Button debouncer: the level changes only after the raw input has held
  its new value for the requested number of cycles.
  Assumes a raw input already synchronous to clk.
*/
`timescale 1ns/1ps
module button_debounce (
  // clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // filter side
  debounce_if.filt dbi
);
  localparam int CW = $bits(dbi.stableCycles);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic level_r, level_nxt;
  logic pulse_r, pulse_nxt;

  always_comb begin
    cnt_nxt = '0;
    level_nxt = level_r;
    pulse_nxt = 1'b0;
    // a glitch shorter than the period restarts the count
    if (dbi.rawPressed != level_r) begin
      if (cnt_r + 1'b1 >= dbi.stableCycles) begin
        level_nxt = dbi.rawPressed;
        pulse_nxt = dbi.rawPressed;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      level_r <= 1'b0;
      pulse_r <= 1'b0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign dbi.pressed = level_r;
  assign dbi.pressPulse = pulse_r;
endmodule : button_debounce

// file: logic/pmic_power_state_reset_control.sv
/*
  Power-state and reset request controller: pin muxing and pulls, pin
  polarities, button debounce, control-port and page-address selection,
  start-up options, off-source reset and restart selection, and the
  power-up and power-down sequencing and the single-step sleep switching of the enable outputs.
  Assumes all inputs synchronous to clk and configuration held steady.
*/
`timescale 1ns/1ps
module pmic_power_state_reset_control #(
  parameter int NUM_RES = 8,
  parameter int SEQ_STEP_CYC = pmic_pkg::SEQ_STEP_CYC,
  parameter int DEB0_CYC = pmic_pkg::DEB0_CYC,
  parameter int DEB1_CYC = pmic_pkg::DEB1_CYC,
  parameter int DEB2_CYC = pmic_pkg::DEB2_CYC,
  parameter int DEB3_CYC = pmic_pkg::DEB3_CYC,
  parameter int DLY1_CYC = pmic_pkg::DLY1_CYC,
  parameter int DLY2_CYC = pmic_pkg::DLY2_CYC,
  parameter int DLY3_CYC = pmic_pkg::DLY3_CYC,
  parameter logic [6:0] PAGE_ADDR_ALT = 7'h13
) (
  // clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // pin configuration
  input wire logic [15:0] gpioFuncSel,
  input wire logic [7:0] pullUpCfg,
  input wire logic [7:0] pullDownCfg,
  input wire logic [7:0] gpioDataOut,
  input wire logic [7:0] gpioDirOut,
  input wire logic [1:0] enableOutDriveSelect,
  // pins
  input wire logic [7:0] gpioIn,
  output logic [7:0] gpioOut,
  output logic [7:0] gpioOeN,
  output logic [7:0] gpioPullUpEn,
  output logic [7:0] gpioPullDownEn,
  output logic regEnAOut,
  output logic regEnAOeN,
  // request pins and sources
  input wire logic powerButtonPinN,
  input wire logic powerDownPin,
  input wire logic resetInPin,
  input wire logic sleepRequestPinN,
  input wire logic onRequest,
  input wire logic longButtonPress,
  input wire logic watchdogExpiry,
  input wire logic thermalShutdown,
  input wire logic softwareResetBit,
  input wire logic supplyLow,
  input wire logic converterShutdown,
  input wire logic oscStable,
  // option configuration
  input wire logic powerDownPolarity,
  input wire logic resetInPolarity,
  input wire logic [1:0] buttonDebounceSelect,
  input wire logic ctrlPortSel,
  input wire logic pageAddressSelect,
  input wire logic gateResetOut,
  input wire logic autoHoldOn,
  input wire logic [1:0] switchOffDelay,
  input wire logic [7:0] hwResetSelect,
  input wire logic [7:0] coldResetSelect,
  input wire logic [NUM_RES-1:0] upSeqMask,
  input wire logic [NUM_RES-1:0] sleepAssign,
  input wire logic sleepMasked,
  input wire logic holdSetReq,
  input wire logic holdClrReq,
  // status
  output logic [NUM_RES-1:0] resourceEn,
  output pmic_pkg::pwr_state_t powerState,
  output logic deviceHoldBit,
  output logic resetOutN,
  output logic hwDomainRst,
  output logic swoDomainRst,
  output logic i2cSelected,
  output logic [6:0] pageAddress,
  output logic buttonPressed
);
  localparam int IW = $clog2(NUM_RES);

  generate
    if (NUM_RES < pmic_pkg::MIN_RES) begin : g_bad_res
      $error("NUM_RES too small for the enable outputs");
    end
  endgenerate

  function automatic logic [31:0] delay_cycles(input logic [1:0] code);
    case (code)
      2'h1: delay_cycles = 32'(DLY1_CYC);
      2'h2: delay_cycles = 32'(DLY2_CYC);
      2'h3: delay_cycles = 32'(DLY3_CYC);
      default: delay_cycles = 32'h0;
    endcase
  endfunction : delay_cycles

  // returns {out, oeN}; open drain only pulls low
  function automatic logic [1:0] drive(input logic level, input logic od);
    drive = od ? {1'b0, level} : {level, 1'b0};
  endfunction : drive

  // button debounce
  debounce_if #(.CW(28)) dbi ();
  logic [27:0] debCycles;
  always_comb begin
    case (buttonDebounceSelect)
      2'h1: debCycles = 28'(DEB1_CYC);
      2'h2: debCycles = 28'(DEB2_CYC);
      2'h3: debCycles = 28'(DEB3_CYC);
      default: debCycles = 28'(DEB0_CYC);
    endcase
  end
  assign dbi.rawPressed = ~powerButtonPinN;
  assign dbi.stableCycles = debCycles;
  button_debounce u_deb (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .dbi(dbi)
  );

  // off sources
  logic holdActive;
  logic [7:0] offSrc;
  always_comb begin
    offSrc = '0;
    offSrc[pmic_pkg::SRC_LONG_PRESS] = longButtonPress;
    offSrc[pmic_pkg::SRC_POWER_DOWN] = powerDownPolarity ? ~powerDownPin : powerDownPin;
    offSrc[pmic_pkg::SRC_WATCHDOG] = watchdogExpiry;
    offSrc[pmic_pkg::SRC_THERMAL] = thermalShutdown;
    offSrc[pmic_pkg::SRC_RESET_IN] = resetInPolarity ? resetInPin : ~resetInPin;
    offSrc[pmic_pkg::SRC_SW_RESET] = softwareResetBit;
    offSrc[pmic_pkg::SRC_SUPPLY_LOW] = supplyLow;
    offSrc[pmic_pkg::SRC_CONVERTER] = converterShutdown;
  end

  // power state group
  pmic_pkg::pwr_state_t state_r, state_nxt;
  logic [IW-1:0] idx_r, idx_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [NUM_RES-1:0] resEn_r, resEn_nxt;
  logic hwKind_r, hwKind_nxt;
  logic cold_r, cold_nxt;
  logic hold_r, hold_nxt;
  logic hardware_reset_r, hardware_reset_nxt;
  logic switch_off_reset_r, switch_off_reset_nxt;
  logic rstOutN_r, rstOutN_nxt;
  logic onReq, offReq, sleepWanted, lastIdx, firstIdx;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    resEn_nxt = resEn_r;
    hwKind_nxt = hwKind_r;
    cold_nxt = cold_r;
    hold_nxt = hold_r;
    hardware_reset_nxt = 1'b0;
    switch_off_reset_nxt = 1'b0;
    onReq = dbi.pressPulse | onRequest | holdActive;
    // losing both hold terms also switches the device off
    offReq = (|offSrc) | ~(hold_r | holdActive);
    // sleep only with assigned, unmasked resources
    sleepWanted = (|sleepAssign) & ~sleepMasked & ~sleepRequestPinN;
    lastIdx = (idx_r == IW'(NUM_RES - 1));
    firstIdx = (idx_r == '0);
    if (holdClrReq) begin
      hold_nxt = 1'b0;
    end
    if (holdSetReq) begin
      hold_nxt = 1'b1;
    end
    case (state_r)
      pmic_pkg::ST_BACKUP: begin
        if (!supplyLow) begin
          state_nxt = pmic_pkg::ST_OFF;
        end
      end
      pmic_pkg::ST_OFF: begin
        // restart unless gated by low supply
        if (supplyLow) begin
          state_nxt = pmic_pkg::ST_BACKUP;
        end else if (onReq || cold_r) begin
          state_nxt = pmic_pkg::ST_UP;
          idx_nxt = '0;
          cnt_nxt = '0;
          cold_nxt = 1'b0;
        end
      end
      pmic_pkg::ST_UP: begin
        if (supplyLow) begin
          state_nxt = pmic_pkg::ST_BACKUP;
          resEn_nxt = '0;
        end else if (!upSeqMask[idx_r] || cnt_r + 32'h1 >= 32'(SEQ_STEP_CYC)) begin
          resEn_nxt[idx_r] = upSeqMask[idx_r];
          cnt_nxt = '0;
          idx_nxt = idx_r + 1'b1;
          if (lastIdx) begin
            state_nxt = pmic_pkg::ST_ACTIVE;
            if (autoHoldOn) begin
              hold_nxt = 1'b1;
            end
          end
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      pmic_pkg::ST_ACTIVE, pmic_pkg::ST_SLEEP: begin
        if (supplyLow) begin
          state_nxt = pmic_pkg::ST_BACKUP;
          resEn_nxt = '0;
          hardware_reset_nxt = hwResetSelect[pmic_pkg::SRC_SUPPLY_LOW];
          switch_off_reset_nxt = 1'b1;
          // set request still wins over the clear
          hold_nxt = pmic_pkg::HOLD_RST | holdSetReq;
        end else if (offReq) begin
          // hardware or switch-off reset per source
          hwKind_nxt = |(offSrc & hwResetSelect);
          // shutdown or cold reset per source
          cold_nxt = |(offSrc & coldResetSelect);
          cnt_nxt = '0;
          idx_nxt = IW'(NUM_RES - 1);
          if (state_r == pmic_pkg::ST_ACTIVE && switchOffDelay != 2'h0) begin
            state_nxt = pmic_pkg::ST_DELAY;
          end else begin
            state_nxt = pmic_pkg::ST_DOWN;
          end
        end else if (state_r == pmic_pkg::ST_ACTIVE && sleepWanted) begin
          state_nxt = pmic_pkg::ST_SLEEP;
          resEn_nxt = resEn_r & ~sleepAssign;
        end else if (state_r == pmic_pkg::ST_SLEEP && !sleepWanted) begin
          state_nxt = pmic_pkg::ST_ACTIVE;
          resEn_nxt = resEn_r | (sleepAssign & upSeqMask);
        end
      end
      pmic_pkg::ST_DELAY: begin
        if (supplyLow) begin
          state_nxt = pmic_pkg::ST_BACKUP;
          resEn_nxt = '0;
          hardware_reset_nxt = hwResetSelect[pmic_pkg::SRC_SUPPLY_LOW];
          switch_off_reset_nxt = 1'b1;
          hold_nxt = pmic_pkg::HOLD_RST | holdSetReq;
        end else if (cnt_r + 32'h1 >= delay_cycles(switchOffDelay)) begin
          state_nxt = pmic_pkg::ST_DOWN;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      pmic_pkg::ST_DOWN: begin
        if (!resEn_r[idx_r] || cnt_r + 32'h1 >= 32'(SEQ_STEP_CYC)) begin
          resEn_nxt[idx_r] = 1'b0;
          cnt_nxt = '0;
          idx_nxt = idx_r - 1'b1;
          if (firstIdx) begin
            state_nxt = pmic_pkg::ST_OFF;
            hardware_reset_nxt = hwKind_r;
            switch_off_reset_nxt = 1'b1;
            // shutdown leaves cold clear and stays off
            hold_nxt = holdSetReq;
          end
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      default: begin
        state_nxt = pmic_pkg::ST_BACKUP;
      end
    endcase
    rstOutN_nxt = (state_nxt == pmic_pkg::ST_ACTIVE || state_nxt == pmic_pkg::ST_SLEEP)
                  && (!gateResetOut || oscStable);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= pmic_pkg::ST_BACKUP;
      idx_r <= '0;
      cnt_r <= '0;
      resEn_r <= '0;
      hwKind_r <= 1'b0;
      cold_r <= 1'b0;
      hold_r <= pmic_pkg::HOLD_RST;
      hardware_reset_r <= 1'b0;
      switch_off_reset_r <= 1'b0;
      rstOutN_r <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
      resEn_r <= resEn_nxt;
      hwKind_r <= hwKind_nxt;
      cold_r <= cold_nxt;
      hold_r <= hold_nxt;
      hardware_reset_r <= hardware_reset_nxt;
      switch_off_reset_r <= switch_off_reset_nxt;
      rstOutN_r <= rstOutN_nxt;
    end
  end

  // pad group
  logic [7:0] gOut_r, gOut_nxt, gOeN_r, gOeN_nxt, pu_r, pu_nxt, pd_r, pd_nxt;
  logic [1:0] regA_r, regA_nxt;
  logic i2c_r, i2c_nxt;
  logic [6:0] page_r, page_nxt;

  always_comb begin
    logic [1:0] fn;
    logic [1:0] drv;
    fn = 2'h0;
    drv = 2'h0;
    gOut_nxt = '0;
    gOeN_nxt = '1;
    pu_nxt = '0;
    pd_nxt = '0;
    for (int i = 0; i < pmic_pkg::NUM_PINS; i++) begin
      fn = gpioFuncSel[2*i +: 2];
      if (fn == pmic_pkg::FUNC_GPIO) begin
        gOut_nxt[i] = gpioDataOut[i];
        gOeN_nxt[i] = ~gpioDirOut[i];
        pu_nxt[i] = pullUpCfg[i];
        pd_nxt[i] = pullDownCfg[i];
      end else if (fn == pmic_pkg::FUNC_ALT) begin
        if (i == pmic_pkg::PIN_REGEN_B) begin
          drv = drive(resEn_r[pmic_pkg::RES_REGEN_B], enableOutDriveSelect[1]);
          gOut_nxt[i] = drv[1];
          gOeN_nxt[i] = drv[0];
        end else if (i == pmic_pkg::PIN_SYSEN_A) begin
          gOut_nxt[i] = resEn_r[pmic_pkg::RES_SYSEN_A];
          gOeN_nxt[i] = 1'b0;
        end else if (i == pmic_pkg::PIN_SYSEN_B) begin
          gOut_nxt[i] = resEn_r[pmic_pkg::RES_SYSEN_B];
          gOeN_nxt[i] = 1'b0;
        end
      end
    end
    regA_nxt = drive(resEn_r[pmic_pkg::RES_REGEN_A], enableOutDriveSelect[0]);
    i2c_nxt = (ctrlPortSel == pmic_pkg::CTRL_I2C);
    page_nxt = pageAddressSelect ? PAGE_ADDR_ALT : pmic_pkg::PAGE_ADDR_DEF;
  end

  // hold input read straight from the pad; pads are synchronous
  assign holdActive = (gpioFuncSel[2*pmic_pkg::PIN_HOLD +: 2] == pmic_pkg::FUNC_HOLD)
                      & gpioIn[pmic_pkg::PIN_HOLD];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gOut_r <= '0;
      gOeN_r <= '1;
      pu_r <= '0;
      pd_r <= '0;
      regA_r <= {1'b0, pmic_pkg::DRIVE_PUSH_PULL};
      i2c_r <= 1'b1;
      page_r <= pmic_pkg::PAGE_ADDR_DEF;
    end else if (clkEn) begin
      gOut_r <= gOut_nxt;
      gOeN_r <= gOeN_nxt;
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
      regA_r <= regA_nxt;
      i2c_r <= i2c_nxt;
      page_r <= page_nxt;
    end
  end

  assign gpioOut = gOut_r;
  assign gpioOeN = gOeN_r;
  assign gpioPullUpEn = pu_r;
  assign gpioPullDownEn = pd_r;
  assign regEnAOut = regA_r[1];
  assign regEnAOeN = regA_r[0];
  assign resourceEn = resEn_r;
  assign powerState = state_r;
  assign deviceHoldBit = hold_r;
  assign resetOutN = rstOutN_r;
  assign hwDomainRst = hardware_reset_r;
  assign swoDomainRst = switch_off_reset_r;
  assign i2cSelected = i2c_r;
  assign pageAddress = page_r;
  assign buttonPressed = dbi.pressed;
endmodule : pmic_power_state_reset_control

// file: verification/pmic_power_state_reset_control_sva.sv
/*
  Port checker of the power-state and reset controller.
  Assumes a bind onto the top module and a single clock domain.
*/
`timescale 1ns/1ps
module pmic_power_state_reset_control_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // configuration
  input wire logic [15:0] gpioFuncSel,
  input wire logic powerDownPolarity,
  input wire logic resetInPolarity,
  input wire logic ctrlPortSel,
  input wire logic pageAddressSelect,
  input wire logic gateResetOut,
  input wire logic [1:0] switchOffDelay,
  // pins
  input wire logic powerDownPin,
  input wire logic resetInPin,
  input wire logic oscStable,
  // outputs
  input wire logic [7:0] gpioPullUpEn,
  input wire logic i2cSelected,
  input wire logic [6:0] pageAddress,
  input wire logic resetOutN,
  input wire logic swoDomainRst,
  input wire pmic_pkg::pwr_state_t powerState
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic isActive = powerState == pmic_pkg::ST_ACTIVE;
  // end of the reverse walk
  sequence downToOff;
    powerState == pmic_pkg::ST_DOWN ##1 powerState == pmic_pkg::ST_OFF;
  endsequence
  pull_gate_a: assert property (clkEn && gpioFuncSel[5:4] != 2'h0 |=> !gpioPullUpEn[2])
    else $error("pull enabled on alternative pin");
  down_pol_a: assert property (clkEn && isActive && (powerDownPin ^ powerDownPolarity)
    |=> !isActive) else $error("power-down pin ignored");
  reset_pol_a: assert property (clkEn && isActive && (resetInPin == resetInPolarity)
    |=> !isActive) else $error("reset input ignored");
  port_sel_a: assert property (clkEn |=> i2cSelected == !$past(ctrlPortSel))
    else $error("control port select wrong");
  page_addr_a: assert property (clkEn && !pageAddressSelect |=> pageAddress == 7'h12)
    else $error("page address wrong");
  reset_gate_a: assert property (clkEn && gateResetOut && !oscStable |=> !resetOutN)
    else $error("reset output released early");
  no_delay_a: assert property (clkEn && isActive && switchOffDelay == 2'h0
    |=> powerState != pmic_pkg::ST_DELAY) else $error("delay with code zero");
  swo_pulse_a: assert property (downToOff |-> swoDomainRst)
    else $error("no switch-off domain reset");
endmodule : pmic_power_state_reset_control_sva

bind pmic_power_state_reset_control pmic_power_state_reset_control_sva u_sva (
  .clk, .sys_rst, .clkEn, .gpioFuncSel, .powerDownPolarity, .resetInPolarity, .ctrlPortSel,
  .pageAddressSelect, .gateResetOut, .switchOffDelay, .powerDownPin, .resetInPin, .oscStable,
  .gpioPullUpEn, .i2cSelected, .pageAddress, .resetOutN, .swoDomainRst, .powerState
);

// file: verification/host_model.sv
/*
  Host processor model: drives the supply-hold input from keepOn and turns a
  wake request into a one-cycle on request. Assumes the bench clock.
*/
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic keepOn,
  input wire logic wake,
  // pins toward the device
  output logic holdPin,
  output logic onPulse
);
  logic wake_r = 1'b0;
  logic pulse_r = 1'b0;
  logic hold_r = 1'b1;
  // one-cycle pulse, so a held wake cannot restart after power-down
  always @(posedge clk) begin
    wake_r <= wake;
    pulse_r <= wake && !wake_r;
    hold_r <= keepOn;
  end
  assign onPulse = pulse_r;
  assign holdPin = hold_r;
endmodule : host_model

// file: verification/pmic_power_state_reset_control_test.sv
/*
  Self-checking bench of the power-state controller with a host model.
  Assumes shortened counts set by parameter and a 100 MHz clock.
*/
`timescale 1ns/1ps
module pmic_power_state_reset_control_test;
  localparam int STEP = 4;
  localparam int DEB = 3;
  logic clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, powerButtonPinN = 1'b1;
  logic sleepRequestPinN = 1'b1, oscStable = 1'b0, powerDownPolarity = 1'b0;
  logic resetInPolarity = 1'b0, ctrlPortSel = 1'b0, pageAddressSelect = 1'b0;
  logic gateResetOut = 1'b0, autoHoldOn = 1'b0, sleepMasked = 1'b0, holdSetReq = 1'b0;
  logic holdClrReq = 1'b0, keepOn = 1'b1, wake = 1'b0;
  logic [15:0] gpioFuncSel = 16'h9110;
  logic [7:0] pullUpCfg = 8'hFF, pullDownCfg = 8'hFF, gpioDataOut = 8'h01, gpioDirOut = 8'h01;
  logic [7:0] src = 8'h00, hwResetSelect = 8'h00, coldResetSelect = 8'h00;
  logic [7:0] upSeqMask = 8'hF3, sleepAssign = 8'h00;
  logic [1:0] enableOutDriveSelect = 2'h0, buttonDebounceSelect = 2'h0, switchOffDelay = 2'h0;
  wire logic holdPin, onRequest, regEnAOut, regEnAOeN, deviceHoldBit, resetOutN;
  wire logic hwDomainRst, swoDomainRst, i2cSelected, buttonPressed;
  wire logic [7:0] gpioOut, gpioOeN, gpioPullUpEn, gpioPullDownEn, resourceEn;
  wire logic [6:0] pageAddress;
  wire pmic_pkg::pwr_state_t powerState;
  wire logic [7:0] gpioIn = {holdPin, 7'h00};
  wire logic powerDownPin = src[1] ^ powerDownPolarity;
  wire logic resetInPin = src[4] ~^ resetInPolarity;
  wire logic longButtonPress = src[0], watchdogExpiry = src[2], thermalShutdown = src[3];
  wire logic softwareResetBit = src[5], supplyLow = src[6], converterShutdown = src[7];
  int mismatches = 0, samplesChecked = 0, hwCnt = 0, swoCnt = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    hwCnt <= hwCnt + int'(hwDomainRst);
    swoCnt <= swoCnt + int'(swoDomainRst);
  end

  host_model u_host_model (.clk, .keepOn, .wake, .holdPin, .onPulse(onRequest));
  pmic_power_state_reset_control #(.SEQ_STEP_CYC(STEP), .DEB0_CYC(DEB), .DEB1_CYC(4),
    .DEB2_CYC(5), .DEB3_CYC(6), .DLY1_CYC(5), .DLY2_CYC(7), .DLY3_CYC(9), .PAGE_ADDR_ALT(7'h13))
    u_pmic_power_state_reset_control (.clk, .sys_rst, .clkEn, .gpioFuncSel, .pullUpCfg,
    .pullDownCfg, .gpioDataOut, .gpioDirOut, .enableOutDriveSelect, .gpioIn, .gpioOut, .gpioOeN,
    .gpioPullUpEn, .gpioPullDownEn, .regEnAOut, .regEnAOeN, .powerButtonPinN, .powerDownPin,
    .resetInPin, .sleepRequestPinN, .onRequest, .longButtonPress, .watchdogExpiry,
    .thermalShutdown, .softwareResetBit, .supplyLow, .converterShutdown, .oscStable,
    .powerDownPolarity, .resetInPolarity, .buttonDebounceSelect, .ctrlPortSel,
    .pageAddressSelect, .gateResetOut, .autoHoldOn, .switchOffDelay, .hwResetSelect,
    .coldResetSelect, .upSeqMask, .sleepAssign, .sleepMasked, .holdSetReq, .holdClrReq,
    .resourceEn, .powerState, .deviceHoldBit, .resetOutN, .hwDomainRst, .swoDomainRst,
    .i2cSelected, .pageAddress, .buttonPressed);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic waitState(input pmic_pkg::pwr_state_t s);
    for (int k = 0; k < 400 && powerState !== s; k++) @(negedge clk);
    check(powerState, s);
  endtask : waitState

  task automatic pwrUp;
    if (powerState === pmic_pkg::ST_OFF) begin
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
    end
    waitState(pmic_pkg::ST_ACTIVE);
    @(negedge clk);
    check(resourceEn, upSeqMask);
    check(resetOutN, !gateResetOut || oscStable);
    check(deviceHoldBit, autoHoldOn);
    check(regEnAOeN, 1'b0);
  endtask : pwrUp

  task automatic initCheck;
    repeat (2) @(negedge clk);
    check(i2cSelected, 1'b1);
    check(pageAddress, 7'h12);
    check(gpioPullUpEn, 8'h2B);
    check(gpioPullDownEn, 8'h2B);
    check({gpioOut[0], gpioOeN[0]}, 2'h2);
    @(posedge clk);
    ctrlPortSel <= 1'b1;
    pageAddressSelect <= 1'b1;
    repeat (2) @(negedge clk);
    check(i2cSelected, 1'b0);
    check(pageAddress, 7'h13);
    @(posedge clk);
    ctrlPortSel <= 1'b0;
    pageAddressSelect <= 1'b0;
  endtask : initCheck

  task automatic buttonOn;
    @(posedge clk);
    powerButtonPinN <= 1'b0;
    repeat (DEB - 1) @(negedge clk);
    check(buttonPressed, 1'b0);
    repeat (5) @(negedge clk);
    check(buttonPressed, 1'b1);
    @(posedge clk);
    powerButtonPinN <= 1'b1;
    pwrUp();
  endtask : buttonOn

  // every off source, each with one reset choice and one restart choice
  task automatic offSources;
    for (int i = 0; i < 8; i++) begin
      int hw0;
      int swo0;
      logic cold;
      cold = i[1] && i != 6;
      @(posedge clk);
      hwResetSelect <= i[0] ? 8'h01 << i : ~(8'h01 << i);
      coldResetSelect <= cold ? 8'h01 << i : ~(8'h01 << i);
      {gateResetOut, autoHoldOn} <= {2{i[2]}};
      {oscStable, powerDownPolarity, resetInPolarity} <= {3{i[0]}};
      switchOffDelay <= i[1:0];
      keepOn <= 1'b1;
      pwrUp();
      hw0 = hwCnt;
      swo0 = swoCnt;
      @(posedge clk);
      src <= 8'h01 << i;
      // host lets go, else the hold input restarts it
      keepOn <= 1'b0;
      repeat (2) @(negedge clk);
      check(powerState, i == 6 ? pmic_pkg::ST_BACKUP : i[1:0] != 2'h0 ? pmic_pkg::ST_DELAY :
        pmic_pkg::ST_DOWN);
      if (i == 6) begin
        @(posedge clk);
        src <= 8'h00;
      end
      waitState(pmic_pkg::ST_OFF);
      @(posedge clk);
      src <= 8'h00;
      repeat (2) @(negedge clk);
      check(powerState, cold ? pmic_pkg::ST_UP : pmic_pkg::ST_OFF);
      check(hwCnt - hw0, i[0]);
      check(swoCnt - swo0, 1);
      check({resourceEn, deviceHoldBit}, 9'h000);
    end
  endtask : offSources

  task automatic sleepCheck;
    pwrUp();
    @(posedge clk);
    sleepRequestPinN <= 1'b0;
    repeat (4) @(negedge clk);
    check(powerState, pmic_pkg::ST_ACTIVE);
    @(posedge clk);
    sleepAssign <= 8'h30;
    sleepMasked <= 1'b1;
    repeat (3) @(negedge clk);
    check(powerState, pmic_pkg::ST_ACTIVE);
    @(posedge clk);
    sleepMasked <= 1'b0;
    repeat (3) @(negedge clk);
    check(powerState, pmic_pkg::ST_SLEEP);
    check(resourceEn, 8'hC3);
    @(posedge clk);
    sleepRequestPinN <= 1'b1;
    enableOutDriveSelect <= 2'h3;
    repeat (3) @(negedge clk);
    check(resourceEn, 8'hF3);
    check(regEnAOeN, 1'b1);
  endtask : sleepCheck

  // frozen clear, set over clear, then a lost hold powers down
  task automatic holdFreeze;
    @(posedge clk);
    clkEn <= 1'b0;
    holdClrReq <= 1'b1;
    repeat (3) @(negedge clk);
    check(deviceHoldBit, 1'b1);
    @(posedge clk);
    clkEn <= 1'b1;
    holdSetReq <= 1'b1;
    repeat (2) @(negedge clk);
    check(deviceHoldBit, 1'b1);
    @(posedge clk);
    holdSetReq <= 1'b0;
    repeat (3) @(negedge clk);
    check(deviceHoldBit, 1'b0);
    check(powerState, pmic_pkg::ST_DELAY);
    @(posedge clk);
    holdClrReq <= 1'b0;
  endtask : holdFreeze

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    initCheck();
    buttonOn();
    offSources();
    sleepCheck();
    holdFreeze();
    end_sim();
  end
endmodule : pmic_power_state_reset_control_test
